// File: shared/dual_timer_pkg.sv
/*
 * Constants, register map and types for the dual 16-bit timer/event counter.
 * Assumes an AHB-Lite register bus with one byte register per aligned word.
 */
`default_nettype none
package dual_timer_pkg;
    localparam int unsigned N_COUNTERS = 2;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned BYTE_W     = 8;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_C0_HIGH = 8'h0C;
    localparam logic [7:0] IDX_C0_LOW  = 8'h0D;
    localparam logic [7:0] IDX_C0_CTRL = 8'h0E;
    localparam logic [7:0] IDX_C1_HIGH = 8'h0F;
    localparam logic [7:0] IDX_C1_LOW  = 8'h10;
    localparam logic [7:0] IDX_C1_CTRL = 8'h11;
    localparam logic [7:0] IDX_IRQ_CTRL = 8'h12;
    localparam logic [7:0] IDX_STRIDE  = 8'h03;

    // Control register fields
    localparam int unsigned CTRL_EDGE_BIT = 3;
    localparam int unsigned CTRL_RUN_BIT  = 4;
    localparam int unsigned CTRL_MODE_LSB = 6;
    localparam logic [7:0]  CTRL_RW_MASK  = 8'hD8;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;

    // Interrupt control fields
    localparam int unsigned IRQ_EN_LSB    = 2;
    localparam int unsigned IRQ_FLAG_LSB  = 5;
    localparam logic [7:0]  IRQ_RW_MASK   = 8'h7F;
    localparam logic [7:0]  IRQ_RESET     = 8'h00;

    // Instruction clock divide
    localparam int unsigned INSTR_DIV     = 4;

    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic [2:0] HSIZE_WORD     = 3'h2;

    typedef enum logic [1:0] {
        MODE_UNUSED = 2'h0,
        MODE_EVENT  = 2'h1,
        MODE_TIMER  = 2'h2,
        MODE_PULSE  = 2'h3
    } mode_t;

    typedef struct packed {
        logic        sel;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] haddr;
    } ahb_req_t;
endpackage : dual_timer_pkg
`default_nettype wire

// File: core/dual_timer_event_counter.sv
/*
 * Two 16-bit count-up timer/event counters with preload, byte-buffered
 * access, pulse width measurement and overflow flags, behind AHB-Lite.
 * Assumes one clock; counter input pins are asynchronous to it.
 */
// Overview of operation
// RULE1 - Two independent 16-bit up-counters, pin or clock divided by four.
// RULE2 - Low byte write fills buffer; high byte write loads full preload.
// RULE3 - High read gives upper byte, saves lower in buffer; low reads it.
// RULE4 - Control bit 3 picks edge: 0 rising, 1 falling.
// RULE5 - Control bit 4 enables counting when set.
// RULE6 - Control bits 0 to 2 and 5 always read zero.
// RULE7 - Bits 7:6 mode: 01 event, 10 timer, 11 pulse width, 00 unused.
// RULE8 - Timer, pulse modes count instruction ticks; event mode pin edges.
// RULE9 - Overflow past FFFF reloads preload and sets flag bit 5 or 6.
// RULE10 - Pulse mode runs from active edge to return edge, then clears run.
// RULE11 - One measurement per enable; triggered by edges, not level.
// RULE12 - Overflow in pulse mode reloads and flags as other modes.
// RULE13 - Event and timer modes never clear enable by hardware.
// RULE14 - Overflow raises a wake-up event.
// RULE15 - Clear irq enable suppresses interrupt request in every mode.
// RULE16 - Preload write while stopped also loads the counter.
// RULE17 - Preload write while running updates only the preload.
// RULE18 - Counting clock is blocked during a counter read.
// RULE19 - External source provides events as pin transitions.
// RULE20 - Flags held until software clears; reload in the overflow cycle.
`default_nettype none
module dual_timer_event_counter
    import dual_timer_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [N_COUNTERS-1:0] counter_input_pin,
    output logic                       irq,
    output logic                       wakeup
);
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // AHB address phase capture
    ahb_req_t    req_q;
    logic        wr_en;
    logic        rd_en;
    logic        rd_go;
    logic [7:0]  wr_idx;
    logic [7:0]  rd_idx;
    logic [7:0]  wbyte;
    logic        addr_ok;

    assign addr_ok = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else if (hready) begin
            req_q.sel    <= hsel && (htrans == HTRANS_NONSEQ) && addr_ok;
            req_q.htrans <= htrans;
            req_q.hwrite <= hwrite;
            req_q.hsize  <= hsize;
            req_q.haddr  <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_en     = req_q.sel && req_q.hwrite;
    assign wr_idx    = req_q.haddr[9:2];
    assign wbyte     = hwdata[BYTE_W-1:0];
    // Reads decoded in address phase so data registers at data phase
    assign rd_go     = hready && hsel && (htrans == HTRANS_NONSEQ)
                       && !hwrite;
    // Only mapped reads have side effects such as buffer capture
    assign rd_en     = rd_go && addr_ok;
    assign rd_idx    = haddr[9:2];

    // Interrupt control: enables bits 3:2, flags bits 6:5
    logic [N_COUNTERS-1:0] irq_en_q;
    logic [N_COUNTERS-1:0] flag_q;
    logic [N_COUNTERS-1:0] ovf;
    logic [6:0]            irq_ctrl_other_q;

    logic [N_COUNTERS-1:0][CNT_W-1:0]  cnt_q;
    logic [N_COUNTERS-1:0][CNT_W-1:0]  preload_q;
    logic [N_COUNTERS-1:0][BYTE_W-1:0] lowbuf_q;
    logic [N_COUNTERS-1:0][BYTE_W-1:0] ctrl_q;
    logic [N_COUNTERS-1:0]             blk_q;
    logic [N_COUNTERS-1:0]             hi_rd;

    // Instruction clock tick, system clock divided by four
    logic [1:0] div_q;
    logic       tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end
    assign tick = (div_q == 2'(INSTR_DIV - 1)); // RULE1

    genvar g;
    generate
        for (g = 0; g < N_COUNTERS; g++) begin : gen_cnt
            localparam logic [7:0] IDX_H = IDX_C0_HIGH + 8'(g) * IDX_STRIDE;
            localparam logic [7:0] IDX_L = IDX_C0_LOW + 8'(g) * IDX_STRIDE;
            localparam logic [7:0] IDX_C = IDX_C0_CTRL + 8'(g) * IDX_STRIDE;

            logic       pin_meta_q;
            logic       pin_sync_q;
            logic       pin_prev_q;
            logic       measuring_q;
            logic       rise;
            logic       fall;
            logic       act_edge;
            logic       ret_edge;
            logic       run;
            logic       edge_sel;
            mode_t      mode;
            logic       inc;
            logic       wr_hi;
            logic       wr_lo;
            logic       wr_ctl;
            logic       pulse_done;

            // Reset to the idle-low pin level, so no false edge after reset
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_q <= 1'b0;
                    pin_sync_q <= 1'b0;
                    pin_prev_q <= 1'b0;
                end else begin
                    pin_meta_q <= counter_input_pin[g];
                    pin_sync_q <= pin_meta_q;
                    pin_prev_q <= pin_sync_q;
                end
            end

            assign rise     = pin_sync_q && !pin_prev_q;
            assign fall     = !pin_sync_q && pin_prev_q;
            assign edge_sel = ctrl_q[g][CTRL_EDGE_BIT];
            assign act_edge = edge_sel ? fall : rise; // RULE4
            assign ret_edge = edge_sel ? rise : fall;
            assign run      = ctrl_q[g][CTRL_RUN_BIT]; // RULE5
            assign mode     = mode_t'(ctrl_q[g][CTRL_MODE_LSB +: 2]); // RULE7
            assign wr_hi    = wr_en && (wr_idx == IDX_H);
            assign wr_lo    = wr_en && (wr_idx == IDX_L);
            assign wr_ctl   = wr_en && (wr_idx == IDX_C);
            assign hi_rd[g] = rd_en && (rd_idx == IDX_H);

            // Measurement window armed by active edge, ended by return edge
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    measuring_q <= 1'b0;
                end else if (!run || mode != MODE_PULSE) begin
                    measuring_q <= 1'b0;
                end else if (!measuring_q && act_edge) begin
                    measuring_q <= 1'b1; // RULE10 RULE11
                end else if (measuring_q && ret_edge) begin
                    measuring_q <= 1'b0;
                end
            end
            assign pulse_done = run && (mode == MODE_PULSE) && measuring_q
                                && ret_edge;

            always_comb begin
                inc = 1'b0;
                unique case (mode)
                    MODE_EVENT:  inc = act_edge; // RULE8 RULE19
                    MODE_TIMER:  inc = tick; // RULE8
                    MODE_PULSE:  inc = tick && measuring_q; // RULE8
                    MODE_UNUSED: inc = 1'b0;
                endcase
                inc = inc && run && !blk_q[g]; // RULE18
            end

            assign ovf[g] = inc && (cnt_q[g] == {CNT_W{1'b1}}); // RULE9 RULE12

            // High read blocks counting for the cycle after the value is latched
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    blk_q[g] <= 1'b0;
                end else begin
                    blk_q[g] <= hi_rd[g]; // RULE18
                end
            end

            // High read wins over a low write landing in the same cycle
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    lowbuf_q[g] <= 8'h00;
                end else if (hi_rd[g]) begin
                    lowbuf_q[g] <= cnt_q[g][BYTE_W-1:0]; // RULE3
                end else if (wr_lo) begin
                    lowbuf_q[g] <= wbyte; // RULE2
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    preload_q[g] <= '0;
                end else if (wr_hi) begin
                    preload_q[g] <= {wbyte, lowbuf_q[g]}; // RULE2 RULE17
                end
            end

            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_q[g] <= '0;
                end else if (wr_hi && !run) begin
                    cnt_q[g] <= {wbyte, lowbuf_q[g]}; // RULE16
                end else if (ovf[g]) begin
                    cnt_q[g] <= preload_q[g]; // RULE9 RULE20
                end else if (inc) begin
                    cnt_q[g] <= cnt_q[g] + CNT_W'(1); // RULE1
                end
            end

            // Only pulse mode clears the enable by hardware
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_q[g] <= CTRL_RESET;
                end else if (wr_ctl) begin
                    ctrl_q[g] <= wbyte & CTRL_RW_MASK; // RULE6
                end else if (pulse_done) begin
                    ctrl_q[g][CTRL_RUN_BIT] <= 1'b0; // RULE10 RULE13
                end
            end
        end
    endgenerate

    logic wr_irq;
    assign wr_irq = wr_en && (wr_idx == IDX_IRQ_CTRL);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q         <= '0;
            irq_ctrl_other_q <= '0;
        end else if (wr_irq) begin
            irq_en_q         <= wbyte[IRQ_EN_LSB +: N_COUNTERS];
            irq_ctrl_other_q <= wbyte[6:0] & IRQ_RW_MASK[6:0];
        end
    end

    // Set wins over a simultaneous software clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else if (wr_irq) begin
            flag_q <= wbyte[IRQ_FLAG_LSB +: N_COUNTERS] | ovf; // RULE20
        end else begin
            flag_q <= flag_q | ovf; // RULE9 RULE20
        end
    end

    assign irq = |(flag_q & irq_en_q); // RULE15

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeup <= 1'b0;
        end else begin
            wakeup <= |ovf; // RULE14
        end
    end

    // Read data, registered at address phase
    logic [7:0] rd_byte;
    logic [7:0] irq_rd;
    always_comb begin
        irq_rd = {1'b0, irq_ctrl_other_q};
        irq_rd[IRQ_EN_LSB +: N_COUNTERS]   = irq_en_q;
        irq_rd[IRQ_FLAG_LSB +: N_COUNTERS] = flag_q;
        irq_rd[7] = 1'b0;
        unique case (rd_idx)
            IDX_C0_HIGH:  rd_byte = cnt_q[0][CNT_W-1:BYTE_W]; // RULE3
            IDX_C0_LOW:   rd_byte = lowbuf_q[0]; // RULE3
            IDX_C0_CTRL:  rd_byte = ctrl_q[0]; // RULE6
            IDX_C1_HIGH:  rd_byte = cnt_q[1][CNT_W-1:BYTE_W]; // RULE3
            IDX_C1_LOW:   rd_byte = lowbuf_q[1]; // RULE3
            IDX_C1_CTRL:  rd_byte = ctrl_q[1]; // RULE6
            IDX_IRQ_CTRL: rd_byte = irq_rd;
            default:      rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (rd_go) begin
            // Unmapped or unaligned reads return zero
            hrdata <= {24'h00_0000, rd_en ? rd_byte : 8'h00};
        end
    end
endmodule : dual_timer_event_counter
`default_nettype wire

// File: dv/timer_properties.sv
/*
 * Concurrent checks on the bus and status ports of the dual counter.
 * Assumes it is bound into the top module and sees only its ports.
 */
`default_nettype none
module timer_properties
    import dual_timer_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        hreadyout,
    input  wire logic        hresp,
    input  wire logic        wakeup
);
    logic rd_go;
    assign rd_go = hsel && htrans == HTRANS_NONSEQ && !hwrite && hready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_zero_wait: assert property (hreadyout == 1'b1)
        else $error("ready dropped");
    a_wake_pulse: assert property (wakeup |=> !wakeup)
        else $error("wake-up longer than one cycle");
    a_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_rdata_hold: assert property (!rd_go |=> $stable(hrdata))
        else $error("read data changed without a read");
    a_ctrl0_zero: assert property (rd_go && haddr == {22'h0, IDX_C0_CTRL,
        2'h0} |=> hrdata[2:0] == 3'h0 && !hrdata[5])
        else $error("counter0 control unused bits set");
    a_ctrl1_zero: assert property (rd_go && haddr == {22'h0, IDX_C1_CTRL,
        2'h0} |=> hrdata[2:0] == 3'h0 && !hrdata[5])
        else $error("counter1 control unused bits set");
    a_unmapped_zero: assert property (rd_go && haddr[31:10] != 22'h0
        |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : timer_properties
bind dual_timer_event_counter timer_properties chk (.clk(clk),
    .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wakeup(wakeup));
`default_nettype wire

// File: dv/event_source.sv
/*
 * Behavioural source of edges on the two counter input pins.
 * Assumes its tasks are called just after a rising clock edge.
 */
`default_nettype none
module event_source (
    input  wire logic       clk,
    output logic      [1:0] pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin = 2'h0;
    // High for hi cycles, then idle low for lo cycles
    task automatic pulse(input int ch, input int hi, input int lo);
        pin[ch] <= 1'b1;
        repeat (hi) @(posedge clk);
        pin[ch] <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask : pulse
    task automatic level(input int ch, input logic v);
        pin[ch] <= v;
    endtask : level
endmodule : event_source
`default_nettype wire

// File: dv/dual_timer_event_counter_test.sv
/*
 * Directed bench for the dual counter over AHB-Lite with a pin source.
 * Assumes zero-wait slave whose ready is fed back as bus ready.
 */
`default_nettype none
module dual_timer_event_counter_test;
    import dual_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, resetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hresp, irq, wakeup;
    wire logic   hready;
    wire logic [1:0] pin;
    logic [7:0]  r;
    logic [15:0] v, v0;
    int          miscompares, compares;
    int          wakes;

    dual_timer_event_counter uut (.clk(clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .counter_input_pin(pin),
        .irq(irq), .wakeup(wakeup));
    event_source src (.clk(clk), .pin(pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Wake-up pulses counted mid-cycle, where the output is settled
    always @(negedge clk) begin
        if (wakeup === 1'b1) begin
            wakes++;
        end
    end

    function automatic logic [31:0] ba(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ba
    task automatic tally_and_finish;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1) begin
            miscompares++;
            $display("ERROR bus ready expected 1 seen %b", hready);
            tally_and_finish();
        end
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        haddr  <= a;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        q = hrdata[7:0];
    endtask : xfer
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        xfer(1'b1, ba(i), d, r);
    endtask : wr
    task automatic rd(input logic [7:0] i, e, input string nm);
        xfer(1'b0, ba(i), 8'h00, r);
        chk(nm, {8'h00, e}, {8'h00, r});
    endtask : rd
    task automatic rdcnt(input logic [7:0] hi, lo, output logic [15:0] q);
        logic [7:0] h, l;
        xfer(1'b0, ba(hi), 8'h00, h);
        xfer(1'b0, ba(lo), 8'h00, l);
        q = {h, l};
    endtask : rdcnt

    initial begin
        resetn      = 1'b0;
        hsel        = 1'b0;
        hwrite      = 1'b0;
        htrans      = 2'h0;
        haddr       = 32'h0;
        hwdata      = 32'h0;
        hsize       = HSIZE_WORD;
        miscompares = 0;
        compares    = 0;
        wakes       = 0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(IDX_C0_CTRL, 8'h00, "ctrl0 reset");
        rd(IDX_IRQ_CTRL, 8'h00, "irq ctrl reset");
        wr(IDX_C0_CTRL, 8'h2F);
        rd(IDX_C0_CTRL, 8'h08, "ctrl0 unused bits");
        // Previous read left nonzero data, so a stale value would show
        xfer(1'b0, 32'h0000_0400, 8'h00, r);
        chk("unmapped", 16'h0000, {8'h00, r});
        wr(IDX_C1_CTRL, 8'h27);
        rd(IDX_C1_CTRL, 8'h00, "ctrl1 unused bits");
        wr(IDX_C0_CTRL, 8'h00);
        wr(IDX_C0_LOW, 8'h34);
        wr(IDX_C0_HIGH, 8'h12);
        rdcnt(IDX_C0_HIGH, IDX_C0_LOW, v);
        chk("stopped load", 16'h1234, v);
        $display("test registers done");
        wr(IDX_C0_LOW, 8'hF0);
        wr(IDX_C0_HIGH, 8'hFF);
        wr(IDX_C0_CTRL, 8'h90);
        repeat (80) @(posedge clk);
        rd(IDX_IRQ_CTRL, 8'h20, "overflow flag");
        chk("wake pulses", 16'h0001, wakes[15:0]);
        chk("irq masked", 16'h0, {15'h0, irq});
        wr(IDX_C0_LOW, 8'h00);
        wr(IDX_C0_HIGH, 8'h80);
        rd(IDX_C0_HIGH, 8'hFF, "running keeps count");
        repeat (70) @(posedge clk);
        rd(IDX_C0_HIGH, 8'h80, "new preload on reload");
        rd(IDX_C0_CTRL, 8'h90, "timer keeps run");
        rd(IDX_IRQ_CTRL, 8'h20, "flag held");
        chk("wake pulses", 16'h0002, wakes[15:0]);
        wr(IDX_IRQ_CTRL, 8'h24);
        #1 chk("irq enabled", 16'h1, {15'h0, irq});
        wr(IDX_IRQ_CTRL, 8'h04);
        #1 chk("irq cleared", 16'h0, {15'h0, irq});
        $display("test timer done");
        wr(IDX_C1_LOW, 8'h00);
        wr(IDX_C1_HIGH, 8'h00);
        wr(IDX_C1_CTRL, 8'h50);
        repeat (3) src.pulse(1, 3, 3);
        repeat (4) @(posedge clk);
        rdcnt(IDX_C1_HIGH, IDX_C1_LOW, v);
        chk("rising events", 16'h0003, v);
        wr(IDX_C1_CTRL, 8'h58);
        src.level(1, 1'b1);
        repeat (8) @(posedge clk);
        rdcnt(IDX_C1_HIGH, IDX_C1_LOW, v);
        chk("rise ignored", 16'h0003, v);
        src.level(1, 1'b0);
        repeat (8) @(posedge clk);
        rdcnt(IDX_C1_HIGH, IDX_C1_LOW, v);
        chk("fall counted", 16'h0004, v);
        rd(IDX_C1_CTRL, 8'h58, "event keeps run");
        $display("test events done");
        wr(IDX_C0_CTRL, 8'h00);
        wr(IDX_C0_LOW, 8'h00);
        wr(IDX_C0_HIGH, 8'h00);
        wr(IDX_C0_CTRL, 8'hD0);
        src.pulse(0, 40, 8);
        rd(IDX_C0_CTRL, 8'hC0, "run cleared");
        rdcnt(IDX_C0_HIGH, IDX_C0_LOW, v0);
        compares++;
        if ((v0 >= 16'h0009 && v0 <= 16'h000B) !== 1'b1) begin
            miscompares++;
            $display("ERROR pulse width expected 9 to 11 seen %h", v0);
        end
        src.pulse(0, 20, 8);
        rdcnt(IDX_C0_HIGH, IDX_C0_LOW, v);
        chk("result held", v0, v);
        wr(IDX_C0_CTRL, 8'hD0);
        src.pulse(0, 20, 8);
        rdcnt(IDX_C0_HIGH, IDX_C0_LOW, v);
        chk("re-armed", v0 + 16'h0005, v);
        $display("test pulse done");
        tally_and_finish();
    end
endmodule : dual_timer_event_counter_test
`default_nettype wire
